/* File: hw/otsb_ctrl.sv */
// Purpose: overtravel stop sequencing and brake release output control
// Assumes: apb slave with one wait state; power_cycle marks a restart
// Notes:   pending settings become active on power_cycle; reset loads the defaults
`timescale 1ns/10ps
module otsb_ctrl #(
  parameter int NTERM = otsb_pkg::OTSB_NTERM
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              power_cycle,
  input  wire logic              forward_limit_input,
  input  wire logic              reverse_limit_input,
  input  wire logic              servo_on,
  input  wire logic              speed_zero,
  output logic                   drive_enable,
  output logic                   stop_torque_en,
  output logic      [8:0]        torque_limit,
  output logic                   zero_clamp,
  output logic      [NTERM-1:0]  brake_release_output_n
);

  // pending and active configuration
  otsb_pkg::otsb_cfg_t pend_q;
  otsb_pkg::otsb_cfg_t pend_d;
  otsb_pkg::otsb_cfg_t act_q;
  otsb_pkg::otsb_cfg_t act_d;
  logic [8:0]          torq_q;
  logic [8:0]          torq_d;
  logic [2:0]          bk_q;
  logic [2:0]          bk_d;

  // apb answer
  logic                pready_q;
  logic                pready_d;
  logic                pslverr_q;
  logic                pslverr_d;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;

  // stop sequencer
  otsb_pkg::otsb_state_t st_q;
  otsb_pkg::otsb_state_t st_d;
  logic                son_q;
  logic                son_d;
  logic                drv_q;
  logic                drv_d;
  logic                stq_q;
  logic                stq_d;
  logic [8:0]          tlim_q;
  logic [8:0]          tlim_d;
  logic                clamp_q;
  logic                clamp_d;
  logic [NTERM-1:0]    bkout_q;
  logic [NTERM-1:0]    bkout_d;

  otsb_pkg::otsb_hit_t hit;
  logic                wr_en;
  logic                rd_go;
  logic                any_hit;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == otsb_pkg::OTSB_CFG_OFS)   ||
              (a == otsb_pkg::OTSB_TORQ_OFS)  ||
              (a == otsb_pkg::OTSB_BKASG_OFS) ||
              (a == otsb_pkg::OTSB_STAT_OFS)  ||
              (a == otsb_pkg::OTSB_ACT_OFS);
  endfunction

  otsb_limit_qual u_qual (
    .forward_limit_input (forward_limit_input),
    .reverse_limit_input (reverse_limit_input),
    .cfg                 (act_q),
    .hit                 (hit)
  );

  assign any_hit = hit.fwd_hit | hit.rev_hit;
  assign rd_go   = psel & penable & ~pready_q;
  assign wr_en   = psel & penable & pready_q & pwrite &
                   addr_ok(paddr);

  // apb handshake, one wait state
  always_comb begin
    pready_d  = rd_go;
    pslverr_d = pslverr_q;
    prdata_d  = prdata_q;
    if (rd_go) begin
      pslverr_d = ~addr_ok(paddr);
      prdata_d  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          otsb_pkg::OTSB_CFG_OFS:   prdata_d = {16'h0000, pend_q};
          otsb_pkg::OTSB_TORQ_OFS:  prdata_d = {23'h000000, torq_q};
          otsb_pkg::OTSB_BKASG_OFS: prdata_d = {29'h0000000, bk_q};
          otsb_pkg::OTSB_STAT_OFS: begin
            prdata_d = {24'h000000, clamp_q, drv_q, stq_q,
                        hit.rev_hit, hit.fwd_hit, st_q};
          end
          otsb_pkg::OTSB_ACT_OFS:   prdata_d = {16'h0000, act_q};
          default:                  prdata_d = 32'h0000_0000;
        endcase
      end
    end else if (!psel) begin
      pslverr_d = 1'b0;
    end
  end

  // configuration registers
  always_comb begin
    pend_d = pend_q;
    torq_d = torq_q;
    bk_d   = bk_q;
    act_d  = act_q;
    if (wr_en) begin
      case (paddr)
        otsb_pkg::OTSB_CFG_OFS:  pend_d = pwdata[15:0];
        otsb_pkg::OTSB_TORQ_OFS: begin
          // out of range values are refused
          if (pwdata[31:0] <= {23'h000000, otsb_pkg::OTSB_TORQ_MAX}) begin
            torq_d = pwdata[8:0];
          end
        end
        otsb_pkg::OTSB_BKASG_OFS: begin
          if (pwdata[31:0] <= NTERM) begin
            bk_d = pwdata[2:0];
          end
        end
        default: pend_d = pend_q;
      endcase
    end
    if (power_cycle) begin
      act_d = pend_q;
    end
  end

  // stop sequencer next state
  always_comb begin
    st_d    = st_q;
    son_d   = servo_on;
    drv_d   = drv_q;
    stq_d   = any_hit;
    tlim_d  = any_hit ? torq_q : otsb_pkg::OTSB_TORQ_MAX;
    clamp_d = 1'b0;
    bkout_d = {NTERM{1'b1}};
    case (st_q)
      otsb_pkg::OTSB_RUN: begin
        drv_d = servo_on;
        if (any_hit && !speed_zero && servo_on) begin
          if (act_q.post_sel == otsb_pkg::OTSB_POST_COAST ||
              (act_q.post_sel == otsb_pkg::OTSB_POST_RST &&
               act_q.stop_sel == otsb_pkg::OTSB_STOP_COAST)) begin
            st_d  = otsb_pkg::OTSB_COAST;
            drv_d = 1'b0;
          end else begin
            st_d  = otsb_pkg::OTSB_BRAKE;
          end
        end
      end
      otsb_pkg::OTSB_BRAKE: begin
        drv_d = 1'b1;
        if (speed_zero) begin
          if (act_q.post_sel == otsb_pkg::OTSB_POST_CLAMP) begin
            st_d    = otsb_pkg::OTSB_CLAMP;
            clamp_d = 1'b1;
          end else begin
            st_d  = otsb_pkg::OTSB_FREE;
            drv_d = 1'b0;
          end
        end
      end
      otsb_pkg::OTSB_COAST, otsb_pkg::OTSB_FREE: begin
        drv_d = 1'b0;
        if (st_q == otsb_pkg::OTSB_COAST && speed_zero) begin
          st_d = otsb_pkg::OTSB_FREE;
        end
        if (servo_on && !son_q) begin
          st_d  = otsb_pkg::OTSB_RUN;
          drv_d = 1'b1;
        end
      end
      otsb_pkg::OTSB_CLAMP: begin
        drv_d   = 1'b1;
        clamp_d = 1'b1;
        if (!any_hit || !servo_on) begin
          st_d    = otsb_pkg::OTSB_RUN;
          drv_d   = servo_on;
          clamp_d = 1'b0;
        end
      end
      default: begin
        st_d  = otsb_pkg::OTSB_RUN;
        drv_d = 1'b0;
      end
    endcase
    // release the brake only while the drive holds the motor
    for (int i = 0; i < NTERM; i++) begin
      if (bk_q == 3'(i + 1)) begin
        bkout_d[i] = ~drv_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pend_q    <= otsb_pkg::OTSB_CFG_RST;
      act_q     <= otsb_pkg::OTSB_CFG_RST;
      torq_q    <= otsb_pkg::OTSB_TORQ_RST;
      bk_q      <= otsb_pkg::OTSB_BK_RST;
      st_q      <= otsb_pkg::OTSB_RUN;
      son_q     <= 1'b0;
      drv_q     <= 1'b0;
      stq_q     <= 1'b0;
      tlim_q    <= otsb_pkg::OTSB_TORQ_MAX;
      clamp_q   <= 1'b0;
      bkout_q   <= {NTERM{1'b1}};
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      pend_q    <= pend_d;
      act_q     <= act_d;
      torq_q    <= torq_d;
      bk_q      <= bk_d;
      st_q      <= st_d;
      son_q     <= son_d;
      drv_q     <= drv_d;
      stq_q     <= stq_d;
      tlim_q    <= tlim_d;
      clamp_q   <= clamp_d;
      bkout_q   <= bkout_d;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign drive_enable           = drv_q;
  assign stop_torque_en         = stq_q;
  assign torque_limit           = tlim_q;
  assign zero_clamp             = clamp_q;
  assign brake_release_output_n = bkout_q;

endmodule

/* File: hw/otsb_pkg.sv */
// Purpose: constants and types for the overtravel stop and brake control
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes:   offsets and layouts below are shared by the design files
// Overview of operation
// - forward limit selection: 3 uses forward input, 9 disables forward checking
// - reverse limit selection: 4 uses reverse input, 9 disables reverse checking
// - limit and stop method settings take effect only after a power cycle
// - method 0: brake with stop torque limit, then leave motor free
// - method 1: coast like servo off, then leave motor free
// - post-stop 1: brake then zero clamp; post-stop 2: coast then free
// - zero clamp keeps position loop closed with zero position command
// - stop torque limit 0 to 300 percent, default 300, no restart needed
// - stop torque limit applies whenever forward or reverse limit is active
// - new servo-on while coasting after limit stop returns motor to control
// - brake release output low releases brake, high holds brake
// - brake release output drives no terminal until a terminal is assigned
// - brake assignment 0 unused (default), 1 to 6 select that terminal
package otsb_pkg;

  localparam logic [7:0]  OTSB_CFG_OFS    = 8'h00;
  localparam logic [7:0]  OTSB_TORQ_OFS   = 8'h04;
  localparam logic [7:0]  OTSB_BKASG_OFS  = 8'h08;
  localparam logic [7:0]  OTSB_STAT_OFS   = 8'h0c;
  localparam logic [7:0]  OTSB_ACT_OFS    = 8'h10;

  localparam int          OTSB_FWD_LSB    = 0;
  localparam int          OTSB_REV_LSB    = 4;
  localparam int          OTSB_STOP_LSB   = 8;
  localparam int          OTSB_POST_LSB   = 12;

  localparam logic [3:0]  OTSB_FWD_RST    = 4'h3;
  localparam logic [3:0]  OTSB_REV_RST    = 4'h4;
  localparam logic [3:0]  OTSB_SEL_OFF    = 4'h9;
  localparam logic [3:0]  OTSB_STOP_RST   = 4'h0;
  localparam logic [3:0]  OTSB_STOP_COAST = 4'h1;
  localparam logic [3:0]  OTSB_POST_RST   = 4'h0;
  localparam logic [3:0]  OTSB_POST_CLAMP = 4'h1;
  localparam logic [3:0]  OTSB_POST_COAST = 4'h2;
  localparam logic [8:0]  OTSB_TORQ_RST   = 9'h12c;
  localparam logic [8:0]  OTSB_TORQ_MAX   = 9'h12c;
  localparam logic [2:0]  OTSB_BK_RST     = 3'h0;
  localparam int          OTSB_NTERM      = 6;

  typedef struct packed {
    logic [3:0] post_sel;
    logic [3:0] stop_sel;
    logic [3:0] rev_sel;
    logic [3:0] fwd_sel;
  } otsb_cfg_t;

  localparam otsb_cfg_t   OTSB_CFG_RST    = '{post_sel: OTSB_POST_RST,
                                              stop_sel: OTSB_STOP_RST,
                                              rev_sel:  OTSB_REV_RST,
                                              fwd_sel:  OTSB_FWD_RST};

  typedef struct packed {
    logic fwd_hit;
    logic rev_hit;
  } otsb_hit_t;

  typedef enum logic [2:0] {
    OTSB_RUN   = 3'b000,
    OTSB_BRAKE = 3'b001,
    OTSB_COAST = 3'b010,
    OTSB_FREE  = 3'b011,
    OTSB_CLAMP = 3'b100
  } otsb_state_t;

endpackage

/* File: hw/otsb_limit_qual.sv */
// Purpose: qualifies the travel limit inputs with the active selections
// Assumes: limit inputs synchronous to pclk, high means motion forbidden
// Notes:   purely combinational
`timescale 1ns/10ps
module otsb_limit_qual (
  input  wire logic               forward_limit_input,
  input  wire logic               reverse_limit_input,
  input  wire otsb_pkg::otsb_cfg_t cfg,
  output otsb_pkg::otsb_hit_t     hit
);

  always_comb begin
    // a selection of 9 masks the input entirely
    hit.fwd_hit = forward_limit_input &
                  (cfg.fwd_sel != otsb_pkg::OTSB_SEL_OFF);
    hit.rev_hit = reverse_limit_input &
                  (cfg.rev_sel != otsb_pkg::OTSB_SEL_OFF);
  end

endmodule

/* File: verif/otsb_ctrl_monitor.sv */
// Purpose: port checker for otsb_ctrl
// Assumes: one pclk domain
// Notes:   bound from the bench top
`timescale 1ns/10ps
module otsb_ctrl_monitor #(
  parameter int NTERM = 6
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             servo_on,
  input wire logic             speed_zero,
  input wire logic             drive_enable,
  input wire logic             stop_torque_en,
  input wire logic [8:0]       torque_limit,
  input wire logic             zero_clamp,
  input wire logic [NTERM-1:0] brake_release_output_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_brake_held: assert property (!drive_enable
    |-> &brake_release_output_n) else $error("brake released");
  a_torque_idle: assert property (!stop_torque_en
    |-> torque_limit == 9'h12c) else $error("idle torque");
  a_torque_range: assert property (stop_torque_en
    |-> torque_limit <= 9'h12c) else $error("torque range");
  a_clamp_powered: assert property (zero_clamp
    |-> drive_enable) else $error("clamp unpowered");
  a_clamp_at_rest: assert property ($rose(zero_clamp)
    |-> $past(speed_zero)) else $error("clamp while moving");
  a_servo_resume: assert property ($rose(servo_on) && !drive_enable
    && !zero_clamp && !stop_torque_en |=> drive_enable)
    else $error("no resume");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_timed: assert property (psel && penable && !$past(penable)
    |=> pready) else $error("ready late");
endmodule

/* File: verif/otsb_plant.sv */
// Purpose: limit switches and motor model
// Assumes: speed in arbitrary units
// Notes:   braking slows faster than coasting
`timescale 1ns/10ps
module otsb_plant (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fwd_at,
  input wire logic rev_at,
  input wire logic drive_enable,
  input wire logic stop_torque_en,
  output logic     forward_limit_input,
  output logic     reverse_limit_input,
  output logic     speed_zero
);
  logic [5:0] spd_q;
  logic [5:0] spd_d;
  assign forward_limit_input = fwd_at;
  assign reverse_limit_input = rev_at;
  assign speed_zero = spd_q == 6'h00;
  always_comb begin
    spd_d = spd_q;
    if (drive_enable && stop_torque_en)
      spd_d = (spd_q > 6'h02) ? spd_q - 6'h02 : 6'h00;
    else if (drive_enable)
      spd_d = 6'h1e;
    else if (spd_q != 6'h00)
      spd_d = spd_q - 6'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) spd_q <= 6'h00;
    else spd_q <= spd_d;
endmodule

/* File: verif/test_otsb_ctrl.sv */
// Purpose: self-checking bench for otsb_ctrl
// Assumes: three-cycle apb access, one wait state
// Notes:   apb results checked from a queue
`timescale 1ns/10ps
module test_otsb_ctrl;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, power_cycle = 1'b0, servo_on = 1'b0;
  logic        fwd_at = 1'b0, rev_at = 1'b0, t;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rng = 32'h1fbb;
  logic        pready, pslverr, speed_zero, drive_enable, stop_torque_en;
  logic        zero_clamp, forward_limit_input, reverse_limit_input;
  logic [8:0]  torque_limit, torq, tq;
  logic [5:0]  brake_release_output_n;
  logic [15:0] act = 16'h0043;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int          n_fail = 0;
  int          total_checks = 0;
  localparam logic [15:0] CFGS [6] = '{16'h0043, 16'h0143, 16'h1043,
                                      16'h2043, 16'h0049, 16'h0093};
  localparam logic [5:0] TRIP = 6'h0f, HOLD = 6'h35, FIN = 6'h34;
  always #4 pclk = ~pclk;
  otsb_ctrl dut (.*);
  otsb_plant plant (.*);
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    exp_q.push_back({err, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic look(input logic de, st, zc, input logic [8:0] q);
    chk("drive", 32'(drive_enable), 32'(de));
    chk("stoptq", 32'(stop_torque_en), 32'(st));
    chk("clamp", 32'(zero_clamp), 32'(zc));
    chk("torque", 32'(torque_limit), 32'(q));
    chk("brake", 32'(brake_release_output_n), de ? 32'h3d : 32'h3f);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", 32'(pslverr), 32'(e[32]));
      if (!pwrite && !e[32]) chk("prdata", prdata, e[31:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge pclk);
    look(1'b0, 1'b0, 1'b0, 9'h12c);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h43, 1'b0);
    apb(1'b0, 8'h04, 32'h12c, 1'b0);
    apb(1'b1, 8'h14, 32'h5, 1'b1);
    rng = xs(rng);
    torq = 9'(rng % 32'h12d);
    apb(1'b1, 8'h04, 32'(torq), 1'b0);
    apb(1'b1, 8'h04, 32'h12d, 1'b0);
    apb(1'b0, 8'h04, 32'(torq), 1'b0);
    apb(1'b1, 8'h08, 32'h2, 1'b0);
    apb(1'b1, 8'h08, 32'h7, 1'b0);
    apb(1'b0, 8'h08, 32'h2, 1'b0);
    $display("registers done");
    for (int m = 0; m < 6; m++) begin
      t = TRIP[m];
      tq = t ? torq : 9'h12c;
      apb(1'b1, 8'h00, 32'(CFGS[m]), 1'b0);
      apb(1'b0, 8'h10, 32'(act), 1'b0);
      power_cycle <= 1'b1;
      @(posedge pclk);
      power_cycle <= 1'b0;
      act = CFGS[m];
      apb(1'b0, 8'h10, 32'(act), 1'b0);
      servo_on <= 1'b1;
      repeat (30) @(posedge pclk);
      fwd_at <= !m[0];
      rev_at <= m[0];
      repeat (3) @(posedge pclk);
      look(HOLD[m], t, 1'b0, tq);
      for (int i = 0; i < 200 && speed_zero !== 1'b1; i++) @(posedge pclk);
      repeat (3) @(posedge pclk);
      look(FIN[m], t, m == 2, tq);
      if (m == 2) apb(1'b0, 8'h0c, 32'hec, 1'b0);
      fwd_at <= 1'b0;
      rev_at <= 1'b0;
      servo_on <= 1'b0;
      repeat (2) @(posedge pclk);
      servo_on <= 1'b1;
      repeat (3) @(posedge pclk);
      look(1'b1, 1'b0, 1'b0, 9'h12c);
      servo_on <= 1'b0;
      $display("mode %0d done", m);
    end
    complete_run();
  end
endmodule
bind otsb_ctrl otsb_ctrl_monitor #(.NTERM(NTERM)) mon (.*);
